/* common/mlsr_map.vh */
// Register map, field positions, reset values and step sizes of the
// monitor limit and setup bank.
// Assumes byte-wide registers at 8-bit addresses on the management bus.
`ifndef MLSR_MAP_VH
`define MLSR_MAP_VH
`define MLSR_ADR_CORE1_OFS 8'hB2
`define MLSR_ADR_CORE2_OFS 8'hB3
`define MLSR_ADR_FAN1_LO 8'hB4
`define MLSR_ADR_FAN1_HI 8'hB5
`define MLSR_ADR_FAN2_LO 8'hB6
`define MLSR_ADR_FAN2_HI 8'hB7
`define MLSR_ADR_FAN3_LO 8'hB8
`define MLSR_ADR_FAN3_HI 8'hB9
`define MLSR_ADR_FAN4_LO 8'hBA
`define MLSR_ADR_FAN4_HI 8'hBB
`define MLSR_ADR_HYST_FILT 8'hBC
`define MLSR_ADR_TACH_VID 8'hBD
`define MLSR_RST_OFS 8'h17
`define MLSR_RST_FAN_LO 8'hFC
`define MLSR_RST_FAN_HI 8'hFF
`define MLSR_RST_CTRL 8'h00
`define MLSR_FAN_LO_MASK 8'hFC
`define MLSR_HYST_MASK 8'h7F
`define MLSR_FAN_NO_CHECK 14'h3FFF
// Offset field positions
`define MLSR_OFS_HI_MSB 7
`define MLSR_OFS_HI_LSB 4
`define MLSR_OFS_LO_MSB 3
`define MLSR_OFS_LO_LSB 0
// Control bit positions
`define MLSR_VH_MSB 2
`define MLSR_VH_LSB 0
`define MLSR_LIM1_BIT 3
`define MLSR_LIM2_BIT 4
`define MLSR_FAN1_BIT 5
`define MLSR_FAN2_BIT 6
`define MLSR_STE_MSB 3
`define MLSR_STE_LSB 0
`define MLSR_LT12_BIT 4
`define MLSR_LT34_BIT 5
`define MLSR_VMODE_MSB 7
`define MLSR_VMODE_LSB 6
// Steps in units of 0.25 mV (a common divisor of 6.25, 12.5 and 25); VID base in mV, scaled by 4 where used
`define MLSR_STEP_LOW_Q 16'h0064
`define MLSR_STEP_HIGH_Q 16'h0032
`define MLSR_STEP_FINE_Q 16'h0019
`define MLSR_VID_BASE_Q 20'h00640
// Decode modes
`define MLSR_VMODE_SIX 2'b00
`define MLSR_VMODE_EXT 2'b01
`define MLSR_VMODE_M1 2'b10
`define MLSR_VMODE_M2 2'b11
`endif

/* logic/mlsr_core_window.v */
// Dynamic core-voltage window of one processor: decodes the VID code,
// forms the upper and lower limits and flags a reading outside them.
// Assumes VID and reading are synchronous to clk; voltage in 0.25 mV units.
`timescale 1ns/10ps
`default_nettype none
`include "mlsr_map.vh"
module mlsr_core_window (
	input wire clk,
	input wire reset,
	input wire clk_en,
	input wire [7:0] ofs_reg,
	input wire [1:0] decode_sel,
	input wire [7:0] vid_code,
	input wire [19:0] volt_q,
	output reg [19:0] vid_volt_ff,
	output reg out_of_window_ff
);
	reg [19:0] nxt_vid_volt;
	reg [19:0] hi_ofs;
	reg [19:0] lo_ofs;
	reg [6:0] steps;
	reg [15:0] unit;

	// Code decode per mode; base minus steps keeps codes monotone
	always @* begin
		case (decode_sel) // [RULE_17] [RULE_18]
		`MLSR_VMODE_SIX: begin
			steps = {1'b0, vid_code[5:0]};
			unit = `MLSR_STEP_HIGH_Q;
		end
		`MLSR_VMODE_EXT, `MLSR_VMODE_M1: begin
			steps = vid_code[6:0];
			unit = `MLSR_STEP_FINE_Q;
		end
		`MLSR_VMODE_M2: begin
			// Lowest VID bit is taken as zero
			steps = vid_code[7:1];
			unit = `MLSR_STEP_HIGH_Q;
		end
		default: begin
			steps = 7'h00;
			unit = `MLSR_STEP_HIGH_Q;
		end
		endcase
		nxt_vid_volt = 20'h00004 * `MLSR_VID_BASE_Q - {13'h0000, steps} * unit;
		// Code 0 is the first step, so add one step to the field value
		hi_ofs = ({16'h0000, ofs_reg[`MLSR_OFS_HI_MSB:`MLSR_OFS_HI_LSB]}
			+ 20'h00001) * `MLSR_STEP_HIGH_Q; // [RULE_03]
		lo_ofs = ({16'h0000, ofs_reg[`MLSR_OFS_LO_MSB:`MLSR_OFS_LO_LSB]}
			+ 20'h00001) * `MLSR_STEP_LOW_Q; // [RULE_02]
	end

	// Registered window compare; lower limit floors at zero
	always @(posedge clk) begin
		if (reset) begin
			vid_volt_ff <= 20'h00000;
			out_of_window_ff <= 1'b0;
		end else if (clk_en) begin
			vid_volt_ff <= nxt_vid_volt;
			out_of_window_ff <= (volt_q > vid_volt_ff + hi_ofs) ||
				((vid_volt_ff > lo_ofs) &&
				(volt_q < vid_volt_ff - lo_ofs)); // [RULE_01] [RULE_20]
		end
	end
endmodule // mlsr_core_window
`default_nettype wire

/* logic/mlsr_regs.v */
// Limit and setup register bank of the hardware monitor: window offsets,
// fan count limits, voltage hysteresis, filter selects, tach and VID modes.
// Assumes a byte-wide register port from the management-bus engine, and
// readings, limits and fan counts already synchronous to clk.
//
// Contract
// RULE_01 - Window is VID voltage plus upper offset, minus lower offset.
// RULE_02 - Lower offset field counts 25 mV steps, code 0 is 25 mV.
// RULE_03 - Upper offset field counts 12.5 mV steps, code 0 is 12.5 mV.
// RULE_04 - Fan limit 14 bits split low/high; count above limit sets both errors.
// RULE_05 - Fan limit errors are not masked by fan drive level.
// RULE_06 - A fan limit of 3FFFh never raises an error.
// RULE_07 - Hysteresis field in ADC counts applies to all voltage limit checks; the code applies none to the two core window checks.
// RULE_08 - Bit 3 selects smoothed temperature for zone 1 limit checks.
// RULE_09 - Bit 4 selects smoothed temperature for zone 2 limit checks.
// RULE_10 - Bit 5 selects smoothed temperature for zone 1 fan control.
// RULE_11 - Bit 6 selects smoothed temperature for zone 2 fan control.
// RULE_12 - Software clears zone smoothing enables before using the selects.
// RULE_13 - Software relaxes limits past hysteresis before clearing errors.
// RULE_14 - Bits 0 to 3 enable smart counting for fans 1 to 4.
// RULE_15 - Bit 4 puts tables 1 and 2 at half-degree resolution.
// RULE_16 - Bit 5 puts tables 3 and 4 at half-degree resolution.
// RULE_17 - Bits 7:6 pick VID decode for value registers and window.
// RULE_18 - Mode 00 six bits 12.5 mV; 01/10 seven at 6.25; 11 upper seven.
// RULE_19 - Reading above high or below low limit sets both error bits.
// RULE_20 - Core reading outside its window sets its error bit in both.
`timescale 1ns/10ps
`default_nettype none
`include "mlsr_map.vh"
module mlsr_regs #(
	parameter NUM_FAN = 4,
	parameter NUM_VOLT = 16
) (
	input wire clk,
	input wire reset,
	input wire clk_en,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_ff,
	output reg reg_hit_ff,
	input wire [NUM_FAN*14-1:0] fan_counts,
	input wire [NUM_VOLT*8-1:0] volt_readings,
	input wire [NUM_VOLT*8-1:0] volt_low_limits,
	input wire [NUM_VOLT*8-1:0] volt_high_limits,
	input wire [15:0] core1_vid_code,
	input wire [15:0] core2_vid_code,
	input wire [39:0] core_volts_q,
	output reg [NUM_FAN-1:0] fan_error_ff,
	output reg [NUM_VOLT-1:0] volt_error_ff,
	output reg [1:0] core_window_error_ff,
	output reg [39:0] core_vid_volts_ff,
	output reg zone1_limit_use_smoothed_ff,
	output reg zone2_limit_use_smoothed_ff,
	output reg zone1_fan_use_smoothed_ff,
	output reg zone2_fan_use_smoothed_ff,
	output reg [NUM_FAN-1:0] fan_smart_count_on_ff,
	output reg table12_half_degree_ff,
	output reg table34_half_degree_ff,
	output reg [1:0] core_code_decode_sel_ff
);
	reg [7:0] core1_ofs_ff;
	reg [7:0] core2_ofs_ff;
	reg [7:0] fan_lo_ff [0:NUM_FAN-1];
	reg [7:0] fan_hi_ff [0:NUM_FAN-1];
	reg [7:0] hyst_filt_ff;
	reg [7:0] tach_vid_ff;
	reg [7:0] nxt_rdata;
	reg nxt_hit;
	wire [2:0] volt_hyst_counts;
	wire [19:0] core1_vid_volt;
	wire [19:0] core2_vid_volt;
	wire core1_out;
	wire core2_out;
	wire [7:0] fan_rel;
	integer i;

	assign volt_hyst_counts = hyst_filt_ff[`MLSR_VH_MSB:`MLSR_VH_LSB];

	// Offset from the first fan register: bits 7:1 pick the fan, bit 0 the byte
	assign fan_rel = reg_addr - `MLSR_ADR_FAN1_LO;

	// Register writes; reserved bits are forced to zero on store
	always @(posedge clk) begin
		if (reset) begin
			core1_ofs_ff <= `MLSR_RST_OFS;
			core2_ofs_ff <= `MLSR_RST_OFS;
			hyst_filt_ff <= `MLSR_RST_CTRL;
			tach_vid_ff <= `MLSR_RST_CTRL;
			for (i = 0; i < NUM_FAN; i = i + 1) begin
				fan_lo_ff[i] <= `MLSR_RST_FAN_LO;
				fan_hi_ff[i] <= `MLSR_RST_FAN_HI;
			end
		end else if (clk_en && reg_wr) begin
			if (reg_addr == `MLSR_ADR_CORE1_OFS)
				core1_ofs_ff <= reg_wdata;
			if (reg_addr == `MLSR_ADR_CORE2_OFS)
				core2_ofs_ff <= reg_wdata;
			if (reg_addr == `MLSR_ADR_HYST_FILT)
				hyst_filt_ff <= reg_wdata & `MLSR_HYST_MASK;
			if (reg_addr == `MLSR_ADR_TACH_VID)
				tach_vid_ff <= reg_wdata;
			for (i = 0; i < NUM_FAN; i = i + 1) begin
				if (fan_rel[7:1] == i[6:0] && !fan_rel[0])
					fan_lo_ff[i] <= reg_wdata & `MLSR_FAN_LO_MASK; // [RULE_04]
				if (fan_rel[7:1] == i[6:0] && fan_rel[0])
					fan_hi_ff[i] <= reg_wdata; // [RULE_04]
			end
		end
	end

	// Read decode; unmapped addresses read zero and miss
	always @* begin
		nxt_rdata = 8'h00;
		nxt_hit = 1'b1;
		case (reg_addr)
		`MLSR_ADR_CORE1_OFS: nxt_rdata = core1_ofs_ff;
		`MLSR_ADR_CORE2_OFS: nxt_rdata = core2_ofs_ff;
		`MLSR_ADR_FAN1_LO: nxt_rdata = fan_lo_ff[0];
		`MLSR_ADR_FAN1_HI: nxt_rdata = fan_hi_ff[0];
		`MLSR_ADR_FAN2_LO: nxt_rdata = fan_lo_ff[1 % NUM_FAN];
		`MLSR_ADR_FAN2_HI: nxt_rdata = fan_hi_ff[1 % NUM_FAN];
		`MLSR_ADR_FAN3_LO: nxt_rdata = fan_lo_ff[2 % NUM_FAN];
		`MLSR_ADR_FAN3_HI: nxt_rdata = fan_hi_ff[2 % NUM_FAN];
		`MLSR_ADR_FAN4_LO: nxt_rdata = fan_lo_ff[3 % NUM_FAN];
		`MLSR_ADR_FAN4_HI: nxt_rdata = fan_hi_ff[3 % NUM_FAN];
		`MLSR_ADR_HYST_FILT: nxt_rdata = hyst_filt_ff;
		`MLSR_ADR_TACH_VID: nxt_rdata = tach_vid_ff;
		default: nxt_hit = 1'b0;
		endcase
	end

	// Read data held until the next read strobe
	always @(posedge clk) begin
		if (reset) begin
			reg_rdata_ff <= 8'h00;
			reg_hit_ff <= 1'b0;
		end else if (clk_en && reg_rd) begin
			reg_rdata_ff <= nxt_rdata;
			reg_hit_ff <= nxt_hit;
		end
	end

	// Control fields to the rest of the monitor, registered outputs
	always @(posedge clk) begin
		if (reset) begin
			zone1_limit_use_smoothed_ff <= 1'b0;
			zone2_limit_use_smoothed_ff <= 1'b0;
			zone1_fan_use_smoothed_ff <= 1'b0;
			zone2_fan_use_smoothed_ff <= 1'b0;
			fan_smart_count_on_ff <= {NUM_FAN{1'b0}};
			table12_half_degree_ff <= 1'b0;
			table34_half_degree_ff <= 1'b0;
			core_code_decode_sel_ff <= 2'b00;
		end else if (clk_en) begin
			// The smoothing enables must be off for these to act
			zone1_limit_use_smoothed_ff <= hyst_filt_ff[`MLSR_LIM1_BIT]; // [RULE_08]
			zone2_limit_use_smoothed_ff <= hyst_filt_ff[`MLSR_LIM2_BIT]; // [RULE_09]
			zone1_fan_use_smoothed_ff <= hyst_filt_ff[`MLSR_FAN1_BIT]; // [RULE_10]
			zone2_fan_use_smoothed_ff <= hyst_filt_ff[`MLSR_FAN2_BIT]; // [RULE_11]
			fan_smart_count_on_ff <=
				tach_vid_ff[`MLSR_STE_LSB +: NUM_FAN]; // [RULE_14]
			table12_half_degree_ff <= tach_vid_ff[`MLSR_LT12_BIT]; // [RULE_15]
			table34_half_degree_ff <= tach_vid_ff[`MLSR_LT34_BIT]; // [RULE_16]
			core_code_decode_sel_ff <=
				tach_vid_ff[`MLSR_VMODE_MSB:`MLSR_VMODE_LSB]; // [RULE_17]
		end
	end

	// Fan limit check; no masking from the fan drive level
	genvar f;
	generate
		for (f = 0; f < NUM_FAN; f = f + 1) begin : g_fan
			wire [13:0] fan_count_limit;
			assign fan_count_limit = {fan_hi_ff[f], fan_lo_ff[f][7:2]}; // [RULE_04]
			always @(posedge clk) begin
				if (reset)
					fan_error_ff[f] <= 1'b0;
				else if (clk_en)
					fan_error_ff[f] <= (fan_count_limit != `MLSR_FAN_NO_CHECK) &&
						(fan_counts[f*14 +: 14] > fan_count_limit); // [RULE_05] [RULE_06]
			end
		end
	endgenerate

	// Voltage limit check with hysteresis: once in error, the reading must
	// come back inside by at least the hysteresis before the flag drops
	genvar v;
	generate
		for (v = 0; v < NUM_VOLT; v = v + 1) begin : g_volt
			wire [8:0] rd;
			wire [8:0] lo;
			wire [8:0] hi;
			wire outside;
			wire inside_far;
			assign rd = {1'b0, volt_readings[v*8 +: 8]};
			assign lo = {1'b0, volt_low_limits[v*8 +: 8]};
			assign hi = {1'b0, volt_high_limits[v*8 +: 8]};
			assign outside = (rd > hi) || (rd < lo); // [RULE_19]
			assign inside_far = (rd + {6'h00, volt_hyst_counts} <= hi) &&
				(rd >= lo + {6'h00, volt_hyst_counts}); // [RULE_07]
			always @(posedge clk) begin
				if (reset)
					volt_error_ff[v] <= 1'b0;
				else if (clk_en)
					volt_error_ff[v] <= outside ||
						(volt_error_ff[v] && !inside_far); // [RULE_07] [RULE_19]
			end
		end
	endgenerate

	mlsr_core_window u_core1 (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.ofs_reg(core1_ofs_ff),
		.decode_sel(core_code_decode_sel_ff),
		.vid_code(core1_vid_code[7:0]),
		.volt_q(core_volts_q[19:0]),
		.vid_volt_ff(core1_vid_volt),
		.out_of_window_ff(core1_out)
	);

	mlsr_core_window u_core2 (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.ofs_reg(core2_ofs_ff),
		.decode_sel(core_code_decode_sel_ff),
		.vid_code(core2_vid_code[7:0]),
		.volt_q(core_volts_q[39:20]),
		.vid_volt_ff(core2_vid_volt),
		.out_of_window_ff(core2_out)
	);

	// Window results re-registered so outputs stay flop-driven
	always @(posedge clk) begin
		if (reset) begin
			core_window_error_ff <= 2'b00;
			core_vid_volts_ff <= 40'h0000000000;
		end else if (clk_en) begin
			core_window_error_ff <= {core2_out, core1_out}; // [RULE_20]
			core_vid_volts_ff <= {core2_vid_volt, core1_vid_volt};
		end
	end
endmodule // mlsr_regs
`default_nettype wire

/* verification/mlsr_regs_assertions.sv */
// Concurrent checks of the limit and setup bank, bound to its top.
// Assumes clk_en held high and one register access per cycle.
`timescale 1ns/10ps
`default_nettype none
module mlsr_chk #(
	parameter NUM_FAN = 4,
	parameter NUM_VOLT = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [NUM_FAN*14-1:0] fan_counts,
	input wire logic [NUM_VOLT*8-1:0] volt_readings,
	input wire logic [NUM_VOLT*8-1:0] volt_low_limits,
	input wire logic [NUM_VOLT*8-1:0] volt_high_limits,
	input wire logic [39:0] core_volts_q,
	input wire logic [NUM_FAN-1:0] fan_error_ff,
	input wire logic [NUM_VOLT-1:0] volt_error_ff,
	input wire logic [1:0] core_window_error_ff,
	input wire logic [39:0] core_vid_volts_ff,
	input wire logic zone1_limit_use_smoothed_ff,
	input wire logic zone2_limit_use_smoothed_ff,
	input wire logic zone1_fan_use_smoothed_ff,
	input wire logic zone2_fan_use_smoothed_ff,
	input wire logic [NUM_FAN-1:0] fan_smart_count_on_ff,
	input wire logic table12_half_degree_ff,
	input wire logic table34_half_degree_ff,
	input wire logic [1:0] core_code_decode_sel_ff
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
logic [7:0] ofs_ff;
logic [7:0] lo_ff;
logic [7:0] hi_ff;
// Window edges rebuilt from the decoded VID voltage, not from the bank
wire [13:0] lim = {hi_ff, lo_ff[7:2]};
wire [19:0] v = core_vid_volts_ff[19:0];
wire [19:0] c = core_volts_q[19:0];
wire [19:0] up = v + 20'h32 * ({16'h0, ofs_ff[7:4]} + 20'h1);
wire [19:0] dn = 20'h64 * ({16'h0, ofs_ff[3:0]} + 20'h1);
wire wbc = reg_wr && reg_addr == 8'hBC;
wire wbd = reg_wr && reg_addr == 8'hBD;
// Shadows of core 1 offsets and fan 1 limit, taken on the same edge
always @(posedge clk) begin
	if (reset) begin
		ofs_ff <= 8'h17;
		lo_ff <= 8'hFC;
		hi_ff <= 8'hFF;
	end else if (reg_wr) begin
		if (reg_addr == 8'hB2) ofs_ff <= reg_wdata;
		if (reg_addr == 8'hB4) lo_ff <= reg_wdata;
		if (reg_addr == 8'hB5) hi_ff <= reg_wdata;
	end
end
AST_MODE_SEL: assert property (
	wbd |-> ##2 core_code_decode_sel_ff == $past(reg_wdata[7:6], 2))
	else $error("decode select does not follow its write");
AST_TACH_LUT: assert property (
	wbd |-> ##2 {table34_half_degree_ff, table12_half_degree_ff,
	fan_smart_count_on_ff} == $past(reg_wdata[5:0], 2))
	else $error("tach and table bits do not follow their write");
AST_FILTER_SEL: assert property (
	wbc |-> ##2 {zone2_fan_use_smoothed_ff, zone1_fan_use_smoothed_ff,
	zone2_limit_use_smoothed_ff, zone1_limit_use_smoothed_ff}
	== $past(reg_wdata[6:3], 2))
	else $error("smoothing selects do not follow their write");
AST_FAN_OVER: assert property (
	(fan_counts[13:0] > lim && lim != 14'h3FFF)[*2] |-> fan_error_ff[0])
	else $error("fan count above limit without error");
AST_FAN_UNLIMITED: assert property (
	(lim == 14'h3FFF)[*2] |-> !fan_error_ff[0])
	else $error("fan error with all-ones limit");
AST_VOLT_HIGH: assert property (
	(volt_readings[7:0] > volt_high_limits[7:0]
	&& volt_high_limits[7:0] != 8'hFF)[*2] |-> volt_error_ff[0])
	else $error("reading above high limit without error");
AST_VOLT_LOW: assert property (
	(volt_readings[7:0] < volt_low_limits[7:0]
	&& volt_high_limits[7:0] != 8'hFF)[*2] |-> volt_error_ff[0])
	else $error("reading below low limit without error");
AST_WIN_HIGH: assert property (
	(c > up && $stable(v) && !reg_wr)[*4] |-> core_window_error_ff[0])
	else $error("core reading above window without error");
AST_WIN_LOW: assert property (
	(v > dn && c < v - dn && $stable(v) && !reg_wr)[*4]
	|-> core_window_error_ff[0])
	else $error("core reading below window without error");
AST_WIN_IN: assert property (
	(c < up && v > dn && c > v - dn && $stable(v) && !reg_wr)[*4]
	|-> !core_window_error_ff[0])
	else $error("core reading inside window flagged");
endmodule // mlsr_chk
bind mlsr_regs mlsr_chk #(.NUM_FAN(NUM_FAN), .NUM_VOLT(NUM_VOLT)) i_chk (
	.clk, .reset, .reg_wr, .reg_addr, .reg_wdata, .fan_counts,
	.volt_readings, .volt_low_limits, .volt_high_limits, .core_volts_q,
	.fan_error_ff, .volt_error_ff, .core_window_error_ff,
	.core_vid_volts_ff, .zone1_limit_use_smoothed_ff,
	.zone2_limit_use_smoothed_ff, .zone1_fan_use_smoothed_ff,
	.zone2_fan_use_smoothed_ff, .fan_smart_count_on_ff,
	.table12_half_degree_ff, .table34_half_degree_ff,
	.core_code_decode_sel_ff
);
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench of the limit and setup bank.
// Assumes the checker arrives by its own bind; clk_en tied high.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
	$display("unexpected %0t got %h exp %h", $time, a, e); end end
module testbench;
logic clk = 1'b0;
logic reset = 1'b1;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic [7:0] reg_addr = 8'h00;
logic [7:0] reg_wdata = 8'h00;
logic [55:0] fan_counts = 56'h0;
logic [127:0] volt_readings = 128'h0;
logic [127:0] volt_low_limits = 128'h0;
logic [127:0] volt_high_limits = 128'h0;
logic [15:0] core1_vid_code = 16'h0;
logic [15:0] core2_vid_code = 16'h0;
logic [39:0] core_volts_q = 40'h0;
wire [7:0] reg_rdata_ff;
wire reg_hit_ff;
wire [3:0] fan_error_ff;
wire [15:0] volt_error_ff;
wire [1:0] core_window_error_ff;
wire [39:0] core_vid_volts_ff;
wire [1:0] core_code_decode_sel_ff;
int n_errors = 0;
int check_count = 0;
int cyc = 0;
logic rd_d_ff = 1'b0;
logic [31:0] seed = 32'h5FC8;
logic [8:0] q[$];
logic [8:0] er;
logic [13:0] lim;
logic [19:0] v, c, up, dn;
logic [8:0] vt[6] = '{9'h103, 9'h0FD, 9'h0FA, 9'h07F, 9'h085, 9'h086};
mlsr_regs i_dut (.clk, .reset, .clk_en(1'b1), .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata_ff, .reg_hit_ff, .fan_counts, .volt_readings,
	.volt_low_limits, .volt_high_limits, .core1_vid_code, .core2_vid_code,
	.core_volts_q, .fan_error_ff, .volt_error_ff, .core_window_error_ff,
	.core_vid_volts_ff, .zone1_limit_use_smoothed_ff(),
	.zone2_limit_use_smoothed_ff(), .zone1_fan_use_smoothed_ff(),
	.zone2_fan_use_smoothed_ff(), .fan_smart_count_on_ff(),
	.table12_half_degree_ff(), .table34_half_degree_ff(),
	.core_code_decode_sel_ff);
always #12.5 clk = ~clk;
function automatic logic [31:0] lfsr(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// Storable bits per address; unmapped places read as zero
function automatic logic [7:0] mk(input int a);
	if (a < 8'hB2 || a > 8'hBD) return 8'h00;
	if (a == 8'hBC) return 8'h7F;
	return (a > 8'hB3 && a < 8'hBC && !a[0]) ? 8'hFC : 8'hFF;
endfunction
function automatic logic [7:0] rv(input int a);
	if (a == 8'hB2 || a == 8'hB3) return 8'h17;
	return (a > 8'hB3 && a < 8'hBC) ? mk(a) : 8'h00;
endfunction
// One-cycle strobe; ends on the edge that takes it
task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
	@(posedge clk);
	reg_wr <= wr;
	reg_rd <= !wr;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge clk);
	reg_wr <= 1'b0;
	reg_rd <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, input logic [7:0] e);
	q.push_back({a >= 8'hB2 && a <= 8'hBD, e});
	acc(1'b0, a, 8'h00);
endtask
task automatic setlim(input logic [13:0] l);
	for (int f = 0; f < 4; f++) begin
		acc(1'b1, 8'hB5 + 8'(2 * f), l[13:6]);
		acc(1'b1, 8'hB4 + 8'(2 * f), {l[5:0], 2'h0});
	end
endtask
task automatic fchk(input logic [55:0] cnt, input logic [3:0] e);
	@(posedge clk);
	fan_counts <= cnt;
	repeat (3) @(negedge clk);
	`CHK(fan_error_ff, e)
endtask
task automatic end_sim;
	if (n_errors == 0 && check_count > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
// Read results land one cycle after the strobe; hang guard
always @(posedge clk) begin
	if (rd_d_ff) begin
		er = q.pop_front();
		`CHK({reg_hit_ff, reg_rdata_ff}, er)
	end
	rd_d_ff <= reg_rd;
	cyc++;
	if (cyc > 4000) begin
		n_errors++;
		end_sim();
	end
end
initial begin
	repeat (10) @(posedge clk);
	reset <= 1'b0;
	for (int i = 8'hB1; i <= 8'hBE; i++) rd(i, rv(i));
	// Random writes, refused bits and unmapped places read back
	for (int i = 8'hB1; i <= 8'hBE; i++) begin
		seed = lfsr(seed);
		acc(1'b1, i, seed[7:0]);
		rd(i, seed[7:0] & mk(i));
	end
	lim = {seed[13:7], 1'b0, seed[5:0]};
	setlim(lim);
	fchk({4{lim}}, 4'h0);
	fchk({4{lim + 14'h1}}, 4'hF);
	setlim(14'h3FFF);
	fchk({4{14'h3FFF}}, 4'h0);
	// Hysteresis of three counts on channel 1
	// Smoothing enables live elsewhere and stay off in this bench
	acc(1'b1, 8'hBC, 8'h03);
	// Limits move only while no voltage error stands
	volt_high_limits[7:0] <= 8'h80;
	volt_low_limits[7:0] <= 8'h40;
	foreach (vt[i]) begin
		@(posedge clk);
		volt_readings[7:0] <= vt[i][8:1];
		repeat (3) @(negedge clk);
		`CHK(volt_error_ff[0], vt[i][0])
	end
	// Every decode mode, window probed just outside and inside
	for (int m = 0; m < 4; m++) begin
		seed = lfsr(seed);
		acc(1'b1, 8'hBD, {m[1:0], 6'h00});
		core1_vid_code <= {12'h0, seed[3:0]};
		core2_vid_code <= {12'h0, seed[3:0]};
		acc(1'b1, 8'hB2, {seed[7:4], 2'h0, seed[9:8]});
		acc(1'b1, 8'hB3, {seed[7:4], 2'h0, seed[9:8]});
		repeat (3) @(negedge clk);
		`CHK(core_code_decode_sel_ff, m[1:0])
		// Expected code voltage: 1.6 V less code times the mode's step
		v = 20'h01900 - (m == 3 ? 20'h00032 * seed[3:1]
			: (m == 0 ? 20'h00032 : 20'h00019) * seed[3:0]);
		`CHK(core_vid_volts_ff, {v, v})
		up = 20'h32 * ({16'h0, seed[7:4]} + 20'h1);
		dn = 20'h64 * ({18'h0, seed[9:8]} + 20'h1);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			c = k == 0 ? v + up + 20'h1 : (k == 1 ? v + up - 20'h1 : v - dn - 20'h1);
			core_volts_q <= {c, c};
			repeat (5) @(negedge clk);
			`CHK(core_window_error_ff, k == 1 ? 2'h0 : 2'h3)
		end
	end
	// Mid-run reset must bring every register back to its reset value
	@(posedge clk);
	reset <= 1'b1;
	repeat (2) @(posedge clk);
	reset <= 1'b0;
	for (int i = 8'hB2; i <= 8'hBD; i++) rd(i, rv(i));
	// Let the last read result reach the compare process
	repeat (2) @(posedge clk);
	end_sim();
end
endmodule // testbench
`default_nettype wire
